// [hdl/pdc_diag_if.sv]
// Handshake between the register bank and the diagnostic sequencer.
interface pdc_diag_if;
  logic req;
  logic done;
  logic launch;
  logic busy;
  modport regs (output req, output done, input launch, input busy);
  modport seq (input req, input done, output launch, output busy);
endinterface : pdc_diag_if

// [hdl/pdc_diag_seq.sv]
// Launch and busy tracking for the active-link cable diagnostic.
module pdc_diag_seq (
  // Clock and reset.
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  // Register bank side.
  pdc_diag_if.seq   diag
);

  typedef enum logic { PDC_IDLE, PDC_RUN } pdc_diag_state_t;

  pdc_diag_state_t state_reg;
  logic            busy_reg;
  logic            launch_reg;

  // A start request while running is dropped; done only ends a run.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= PDC_IDLE;
      busy_reg  <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        PDC_IDLE:
        begin
          if (diag.req)
          begin
            state_reg <= PDC_RUN;
            busy_reg  <= 1'b1;
          end
        end
        PDC_RUN:
        begin
          if (diag.done)
          begin
            state_reg <= PDC_IDLE;
            busy_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

  // One-cycle launch pulse toward the diagnostic engine.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      launch_reg <= 1'b0;
    else
      launch_reg <= diag.req && (state_reg == PDC_IDLE);
  end

  assign diag.busy   = busy_reg;
  assign diag.launch = launch_reg;

endmodule // pdc_diag_seq

// [hdl/pdc_pkg.sv]
// Constants of the receive DSP tuning and cable diagnostic register bank.
package pdc_pkg;

  //==========================================================================
  // Geometry
  localparam int NUM_REGS = 16;
  localparam int SLOT_W   = 4;
  localparam int IDX_W    = 10;
  localparam int MIN_AW   = 12;

  //==========================================================================
  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_FILT_CFG1 = 10'h106;
  localparam logic [9:0] IDX_FILT_CFG2 = 10'h107;
  localparam logic [9:0] IDX_SP_CFG2   = 10'h10F;
  localparam logic [9:0] IDX_SP_CFG3   = 10'h111;
  localparam logic [9:0] IDX_FBE_CTRL  = 10'h114;
  localparam logic [9:0] IDX_GAIN_BW   = 10'h116;
  localparam logic [9:0] IDX_BAD_THR   = 10'h121;
  localparam logic [9:0] IDX_TL_THR    = 10'h122;
  localparam logic [9:0] IDX_LU_THR    = 10'h123;
  localparam logic [9:0] IDX_TRN_TMR   = 10'h126;
  localparam logic [9:0] IDX_GAIN_LIM  = 10'h129;
  localparam logic [9:0] IDX_SP_CFG5   = 10'h130;
  localparam logic [9:0] IDX_ACTIVE_LINK_CABLE_DIAG_CTL  = 10'h155;
  localparam logic [9:0] IDX_CD_CTL1   = 10'h170;
  localparam logic [9:0] IDX_CD_CTL2   = 10'h171;
  localparam logic [9:0] IDX_CD_CTL3   = 10'h173;

  //==========================================================================
  // Reset values.
  localparam logic [15:0] RST_FILT_CFG1 = 16'hB0BB;
  localparam logic [15:0] RST_FILT_CFG2 = 16'h0605;
  localparam logic [15:0] RST_SP_CFG2   = 16'h0300;
  localparam logic [15:0] RST_SP_CFG3   = 16'h6003;
  localparam logic [15:0] RST_FBE_CTRL  = 16'h400A;
  localparam logic [15:0] RST_GAIN_BW   = 16'h014A;
  localparam logic [15:0] RST_BAD_THR   = 16'h199A;
  localparam logic [15:0] RST_TL_THR    = 16'h1027;
  localparam logic [15:0] RST_LU_THR    = 16'h051C;
  localparam logic [15:0] RST_TRN_TMR   = 16'h461B;
  localparam logic [15:0] RST_GAIN_LIM  = 16'h000F;
  localparam logic [15:0] RST_SP_CFG5   = 16'h0001;
  localparam logic [15:0] RST_ACTIVE_LINK_CABLE_DIAG_CTL  = 16'h0001;
  localparam logic [15:0] RST_CD_CTL1   = 16'h0E52;
  localparam logic [15:0] RST_CD_CTL2   = 16'hC85C;
  localparam logic [15:0] RST_CD_CTL3   = 16'hFF1E;
  localparam logic [6:0]  RST_AVG_CYC   = 7'h40;

  //==========================================================================
  // Slot tables, in slot order.
  localparam logic [9:0] REG_IDX [NUM_REGS] = '{
    IDX_FILT_CFG1, IDX_FILT_CFG2, IDX_SP_CFG2, IDX_SP_CFG3,
    IDX_FBE_CTRL, IDX_GAIN_BW, IDX_BAD_THR, IDX_TL_THR,
    IDX_LU_THR, IDX_TRN_TMR, IDX_GAIN_LIM, IDX_SP_CFG5,
    IDX_ACTIVE_LINK_CABLE_DIAG_CTL, IDX_CD_CTL1, IDX_CD_CTL2, IDX_CD_CTL3};
  localparam logic [15:0] REG_RST [NUM_REGS] = '{
    RST_FILT_CFG1, RST_FILT_CFG2, RST_SP_CFG2, RST_SP_CFG3,
    RST_FBE_CTRL, RST_GAIN_BW, RST_BAD_THR, RST_TL_THR,
    RST_LU_THR, RST_TRN_TMR, RST_GAIN_LIM, RST_SP_CFG5,
    RST_ACTIVE_LINK_CABLE_DIAG_CTL, RST_CD_CTL1, RST_CD_CTL2, RST_CD_CTL3};
  // Writable bits; read-only and status bits are cleared here.
  localparam logic [15:0] REG_WMASK [NUM_REGS] = '{
    16'hF7FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF,
    16'h7FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h000F, 16'h7FFF, 16'hFFFF, 16'hFFFF};
  localparam logic [3:0] SLOT_FILT_CFG1 = 4'h0;
  localparam logic [3:0] SLOT_FILT_CFG2 = 4'h1;
  localparam logic [3:0] SLOT_SP_CFG2   = 4'h2;
  localparam logic [3:0] SLOT_SP_CFG3   = 4'h3;
  localparam logic [3:0] SLOT_FBE_CTRL  = 4'h4;
  localparam logic [3:0] SLOT_GAIN_BW   = 4'h5;
  localparam logic [3:0] SLOT_BAD_THR   = 4'h6;
  localparam logic [3:0] SLOT_TL_THR    = 4'h7;
  localparam logic [3:0] SLOT_LU_THR    = 4'h8;
  localparam logic [3:0] SLOT_TRN_TMR   = 4'h9;
  localparam logic [3:0] SLOT_GAIN_LIM  = 4'hA;
  localparam logic [3:0] SLOT_SP_CFG5   = 4'hB;
  localparam logic [3:0] SLOT_ACTIVE_LINK_CABLE_DIAG_CTL  = 4'hC;
  localparam logic [3:0] SLOT_CD_CTL1   = 4'hD;
  localparam logic [3:0] SLOT_CD_CTL2   = 4'hE;
  localparam logic [3:0] SLOT_CD_CTL3   = 4'hF;

  //==========================================================================
  // Field positions.
  localparam int ACTIVE_LINK_CABLE_DIAG_START_BIT = 15;
  localparam int ACTIVE_LINK_CABLE_DIAG_BUSY_BIT  = 12;
  localparam int ACTIVE_LINK_CABLE_DIAG_SUM_LSB   = 4;
  localparam int CROSS_DIS_BIT  = 14;
  localparam int TX_BYP_BIT     = 13;
  localparam int RX_BYP_BIT     = 12;
  localparam int AVG_LSB        = 8;
  localparam logic [2:0] AVG_RSVD = 3'h7;
  localparam int LISTEN_LSB     = 8;
  localparam int THR1_LSB       = 12;
  localparam int COEF_EN_BIT    = 10;
  localparam int COEF_LONG_LSB  = 6;
  localparam int LOOP_IN_BIT    = 8;
  localparam int GAIN_MAX_LSB   = 4;
  localparam int RETRAIN_DIS_BIT = 11;
  localparam int TMR1_LSB       = 12;
  localparam int TMR2_LSB       = 6;
  localparam int TMR3_LSB       = 3;

endpackage : pdc_pkg

// [hdl/pdc_regs.sv]
// APB register bank for receive DSP tuning and cable diagnostics.
//============================================================================
// Functional notes
// - Writing one to start launches diagnostic.
// - Status reads one while diagnostic runs.
// - Cross-mode disable stops opposite pair check.
// - Transmit pair bypass skips that pair.
// - Receive pair bypass skips that pair.
// - Averaging code n selects 2^n cycles; reserved code 7 selects 64.
// - Pulse control sets expected self reflection.
// - Cable length sets listening duration.
// - Two short-cable thresholds pick coefficient sets.
// - Enable internal coefficient in steady state.
// - Long-cable filter coefficient field.
// - Select input kind of gain loop.
// - Starting gain index field.
// - Gain index upper and lower limits.
// - Disable gain retraining bit.
// - Bad error threshold triggers recovery state.
// - Timing loop good error threshold.
// - Link-up good error threshold.
// - Training timers for state, timing, gain.
//============================================================================
//
// Chosen here: the APB slave port.
module pdc_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  // APB slave.
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  // Digital filter.
  output logic [3:0]             filt_thr_set1_o,
  output logic [3:0]             filt_thr_set0_o,
  output logic                   filt_coef_en_o,
  output logic [1:0]             filt_coef_long_o,
  output logic [15:0]            filt_cfg2_o,
  // Gain loop.
  output logic                   gain_loop_in_sel_o,
  output logic [3:0]             gain_start_idx_o,
  output logic [3:0]             gain_idx_max_o,
  output logic [3:0]             gain_idx_min_o,
  output logic                   gain_retrain_dis_o,
  output logic [15:0]            fbe_ctrl_o,
  output logic [15:0]            gain_bw_o,
  // Error thresholds.
  output logic [14:0]            bad_err_thr_o,
  output logic [14:0]            timing_loop_error_level_thr_o,
  output logic [14:0]            linkup_error_level_thr_o,
  // Training timers.
  output logic [2:0]             trn_tmr_shift_o,
  output logic [5:0]             trn_tmr_timing_o,
  output logic [2:0]             trn_tmr_gain_a_o,
  output logic [2:0]             trn_tmr_gain_b_o,
  // Active-link cable diagnostic.
  output logic                   active_link_cable_diag_start_o,
  output logic                   active_link_cable_diag_busy_o,
  input  wire logic              active_link_cable_diag_done_i,
  input  wire logic [7:0]        active_link_cable_diag_sum_i,
  // Reflectometry.
  output logic                   tdr_cross_dis_o,
  output logic                   transmit_pair_bypass_o,
  output logic                   receive_pair_bypass_o,
  output logic [6:0]             tdr_avg_cycles_o,
  output logic [3:0]             tdr_pulse_ctrl_o,
  output logic [7:0]             tdr_listen_len_o
);

  //==========================================================================
  // Elaboration check
  if (ADDR_W < pdc_pkg::MIN_AW || ADDR_W > 32)
  begin : g_bad_aw
    $error("ADDR_W must lie between 12 and 32");
  end

  //==========================================================================
  // Declarations
  logic [15:0]               cfg_reg [pdc_pkg::NUM_REGS];
  logic                      pready_reg;
  logic [31:0]               prdata_reg;
  logic                      pslverr_reg;
  logic [6:0]                avg_cycles_reg;
  logic                      hit;
  logic [pdc_pkg::SLOT_W-1:0] slot;
  logic                      setup;
  logic                      acc;
  logic                      wr_en;
  logic [15:0]               wmask;
  logic [15:0]               rd_word;
  logic [2:0]                avg_code;

  pdc_diag_if diag ();

  //==========================================================================
  // Address decode
  // Misaligned addresses are treated as unmapped rather than rounded down.
  always_comb
  begin
    hit  = 1'b0;
    slot = '0;
    for (int i = 0; i < pdc_pkg::NUM_REGS; i++)
    begin
      if (paddr_i[ADDR_W-1:2] == (ADDR_W-2)'(pdc_pkg::REG_IDX[i]))
      begin
        hit  = 1'b1;
        slot = i[pdc_pkg::SLOT_W-1:0];
      end
    end
    if (paddr_i[1:0] != 2'h0)
      hit = 1'b0;
  end

  // Phase qualifiers; writes commit only at the completing access edge.
  assign setup = psel_i && !penable_i;
  assign acc   = psel_i && penable_i && pready_reg;
  assign wr_en = acc && pwrite_i && hit;
  assign wmask = pdc_pkg::REG_WMASK[slot] & {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  //==========================================================================
  // Register storage
  // Read-only bits never change because their write mask is zero.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < pdc_pkg::NUM_REGS; i++)
        cfg_reg[i] <= pdc_pkg::REG_RST[i];
    end
    else if (wr_en)
    begin
      cfg_reg[slot] <= (cfg_reg[slot] & ~wmask) | (pwdata_i[15:0] & wmask);
    end
  end

  //==========================================================================
  // Read data
  // The start bit is not stored, so it always reads back as zero.
  always_comb
  begin
    rd_word = cfg_reg[slot];
    if (slot == pdc_pkg::SLOT_ACTIVE_LINK_CABLE_DIAG_CTL)
    begin
      rd_word[pdc_pkg::ACTIVE_LINK_CABLE_DIAG_BUSY_BIT] = diag.busy;
      rd_word[pdc_pkg::ACTIVE_LINK_CABLE_DIAG_SUM_LSB +: 8] = active_link_cable_diag_sum_i;
    end
    if (!hit)
      rd_word = '0;
  end

  // Answer is prepared in the setup cycle, so the access needs no wait.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup;
      if (setup)
      begin
        prdata_reg  <= pwrite_i ? 32'h0000_0000 : {16'h0000, rd_word};
        pslverr_reg <= !hit;
      end
    end
  end

  assign pready_o  = pready_reg;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg;

  //==========================================================================
  // Active-link diagnostic launch
  // A start request is only the byte write; the sequencer owns busy.
  assign diag.req  = wr_en && (slot == pdc_pkg::SLOT_ACTIVE_LINK_CABLE_DIAG_CTL) && pstrb_i[1]
                     && pwdata_i[pdc_pkg::ACTIVE_LINK_CABLE_DIAG_START_BIT];
  assign diag.done = active_link_cable_diag_done_i;

  pdc_diag_seq u_diag_seq (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .diag      (diag.seq)
  );

  assign active_link_cable_diag_start_o = diag.launch;
  assign active_link_cable_diag_busy_o  = diag.busy;

  //==========================================================================
  // Averaging count
  // The reserved code saturates at the longest average instead of wrapping.
  assign avg_code = cfg_reg[pdc_pkg::SLOT_CD_CTL1][pdc_pkg::AVG_LSB +: 3];

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avg_cycles_reg <= pdc_pkg::RST_AVG_CYC;
    else if (avg_code == pdc_pkg::AVG_RSVD)
      avg_cycles_reg <= pdc_pkg::RST_AVG_CYC;
    else
      avg_cycles_reg <= 7'h01 << avg_code;
  end

  assign tdr_avg_cycles_o = avg_cycles_reg;

  //==========================================================================
  // Field outputs, taken straight from the register flops.
  assign filt_thr_set1_o  = cfg_reg[pdc_pkg::SLOT_FILT_CFG1][pdc_pkg::THR1_LSB +: 4];
  assign filt_thr_set0_o  = cfg_reg[pdc_pkg::SLOT_FILT_CFG1][3:0];
  assign filt_coef_en_o   = cfg_reg[pdc_pkg::SLOT_FILT_CFG1][pdc_pkg::COEF_EN_BIT];
  assign filt_coef_long_o = cfg_reg[pdc_pkg::SLOT_FILT_CFG1][pdc_pkg::COEF_LONG_LSB +: 2];
  assign filt_cfg2_o      = cfg_reg[pdc_pkg::SLOT_FILT_CFG2];

  // Gain loop controls.
  assign gain_loop_in_sel_o = cfg_reg[pdc_pkg::SLOT_SP_CFG2][pdc_pkg::LOOP_IN_BIT];
  assign gain_start_idx_o   = cfg_reg[pdc_pkg::SLOT_SP_CFG3][3:0];
  assign gain_idx_max_o     = cfg_reg[pdc_pkg::SLOT_GAIN_LIM][pdc_pkg::GAIN_MAX_LSB +: 4];
  assign gain_idx_min_o     = cfg_reg[pdc_pkg::SLOT_GAIN_LIM][3:0];
  assign gain_retrain_dis_o = cfg_reg[pdc_pkg::SLOT_SP_CFG5][pdc_pkg::RETRAIN_DIS_BIT];
  assign fbe_ctrl_o         = cfg_reg[pdc_pkg::SLOT_FBE_CTRL];
  assign gain_bw_o          = cfg_reg[pdc_pkg::SLOT_GAIN_BW];

  // Error thresholds.
  assign bad_err_thr_o                 = cfg_reg[pdc_pkg::SLOT_BAD_THR][14:0];
  assign timing_loop_error_level_thr_o = cfg_reg[pdc_pkg::SLOT_TL_THR][14:0];
  assign linkup_error_level_thr_o      = cfg_reg[pdc_pkg::SLOT_LU_THR][14:0];

  // Training timers.
  assign trn_tmr_shift_o  = cfg_reg[pdc_pkg::SLOT_TRN_TMR][pdc_pkg::TMR1_LSB +: 3];
  assign trn_tmr_timing_o = cfg_reg[pdc_pkg::SLOT_TRN_TMR][pdc_pkg::TMR2_LSB +: 6];
  assign trn_tmr_gain_a_o = cfg_reg[pdc_pkg::SLOT_TRN_TMR][pdc_pkg::TMR3_LSB +: 3];
  assign trn_tmr_gain_b_o = cfg_reg[pdc_pkg::SLOT_TRN_TMR][2:0];

  // Reflectometry setup.
  assign tdr_cross_dis_o        = cfg_reg[pdc_pkg::SLOT_CD_CTL1][pdc_pkg::CROSS_DIS_BIT];
  assign transmit_pair_bypass_o = cfg_reg[pdc_pkg::SLOT_CD_CTL1][pdc_pkg::TX_BYP_BIT];
  assign receive_pair_bypass_o  = cfg_reg[pdc_pkg::SLOT_CD_CTL1][pdc_pkg::RX_BYP_BIT];
  assign tdr_pulse_ctrl_o       = cfg_reg[pdc_pkg::SLOT_CD_CTL2][3:0];
  assign tdr_listen_len_o       = cfg_reg[pdc_pkg::SLOT_CD_CTL3][pdc_pkg::LISTEN_LSB +: 8];

  //==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_wr_full(logic [3:0] s);
    wr_en && slot == s && pstrb_i == 4'hF;
  endsequence

  sequence s_start_idle;
    s_wr_full(pdc_pkg::SLOT_ACTIVE_LINK_CABLE_DIAG_CTL) ##0 pwdata_i[15] && !diag.busy;
  endsequence

  property p_launch;
    s_start_idle |=> active_link_cable_diag_start_o && active_link_cable_diag_busy_o
      ##1 !active_link_cable_diag_start_o;
  endproperty
  a_launch: assert property (p_launch) else $error("start write did not launch once");

  property p_no_launch;
    s_wr_full(pdc_pkg::SLOT_ACTIVE_LINK_CABLE_DIAG_CTL) ##0 !pwdata_i[15] && !diag.busy
      |=> !active_link_cable_diag_start_o && !active_link_cable_diag_busy_o;
  endproperty
  a_no_launch: assert property (p_no_launch) else $error("zero write started a diagnostic");

  property p_busy_hold;
    active_link_cable_diag_busy_o && !active_link_cable_diag_done_i |=> active_link_cable_diag_busy_o;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("status dropped before done");

  property p_busy_end;
    active_link_cable_diag_busy_o && active_link_cable_diag_done_i |=> !active_link_cable_diag_busy_o;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("status stayed high after done");

  property p_start_rd;
    setup && !pwrite_i && hit && slot == pdc_pkg::SLOT_ACTIVE_LINK_CABLE_DIAG_CTL
      |=> !prdata_o[15] && prdata_o[12] == $past(diag.busy);
  endproperty
  a_start_rd: assert property (p_start_rd) else $error("start or status read back wrong");

  property p_cross;
    s_wr_full(pdc_pkg::SLOT_CD_CTL1) |=> tdr_cross_dis_o == $past(pwdata_i[14])
      && transmit_pair_bypass_o == $past(pwdata_i[13]) && receive_pair_bypass_o == $past(pwdata_i[12]);
  endproperty
  a_cross: assert property (p_cross) else $error("pair controls not updated");

  property p_avg;
    s_wr_full(pdc_pkg::SLOT_CD_CTL1) ##0 pwdata_i[10:8] != 3'h7
      |=> ##1 tdr_avg_cycles_o == (7'h01 << $past(pwdata_i[10:8], 2));
  endproperty
  a_avg: assert property (p_avg) else $error("average count wrong");

  property p_bad_thr;
    s_wr_full(pdc_pkg::SLOT_BAD_THR) |=> bad_err_thr_o == $past(pwdata_i[14:0]);
  endproperty
  a_bad_thr: assert property (p_bad_thr) else $error("bad error threshold not updated");

  property p_limits;
    s_wr_full(pdc_pkg::SLOT_GAIN_LIM) |=> gain_idx_max_o == $past(pwdata_i[7:4])
      && gain_idx_min_o == $past(pwdata_i[3:0]);
  endproperty
  a_limits: assert property (p_limits) else $error("gain limits not updated");

  sequence s_start_busy;
    s_wr_full(pdc_pkg::SLOT_ACTIVE_LINK_CABLE_DIAG_CTL) ##0 pwdata_i[15] && diag.busy;
  endsequence

  // Busy is not required here, because a done in the same cycle may end the run.
  property p_refuse;
    s_start_busy |=> !active_link_cable_diag_start_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start while busy launched again");

  property p_unmapped;
    setup && !hit |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_tl_thr;
    s_wr_full(pdc_pkg::SLOT_TL_THR) |=> timing_loop_error_level_thr_o == $past(pwdata_i[14:0]);
  endproperty
  a_tl_thr: assert property (p_tl_thr) else $error("timing loop threshold not updated");

  property p_lu_thr;
    s_wr_full(pdc_pkg::SLOT_LU_THR) |=> linkup_error_level_thr_o == $past(pwdata_i[14:0]);
  endproperty
  a_lu_thr: assert property (p_lu_thr) else $error("link-up threshold not updated");

  property p_timers;
    s_wr_full(pdc_pkg::SLOT_TRN_TMR) |=> {trn_tmr_shift_o, trn_tmr_timing_o, trn_tmr_gain_a_o, trn_tmr_gain_b_o}
      == $past(pwdata_i[14:0]);
  endproperty
  a_timers: assert property (p_timers) else $error("training timers not updated");

  property p_answer;
    setup |=> pready_o ##1 !pready_o;
  endproperty
  a_answer: assert property (p_answer) else $error("pready not a single cycle after setup");

endmodule // pdc_regs

// [tb/test_phy_dsp_and_cable_diag_regs.sv]
// Self-checking bench for the receive DSP tuning and cable diagnostic register bank.
module test_phy_dsp_and_cable_diag_regs;
  timeunit 1ns;
  timeprecision 100ps;

  //==========================================================================
  // Signals
  typedef struct packed {logic [15:0] pat; logic [6:0] avg;} pdc_row_t;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  sum = 8'h00;
  logic        pready, pslverr, coef_en, loop_sel, retrain_dis, start, busy, cross_dis, tx_byp, rx_byp;
  logic [31:0] prdata, rd;
  logic        err;
  logic [1:0]  coef_long;
  logic [3:0]  thr1, thr0, gain_start, gain_max, gain_min, pulse;
  logic [15:0] cfg2, fbe, gain_bw;
  logic [14:0] bad_thr, tl_thr, lu_thr;
  logic [2:0]  tmr_shift, tmr_ga, tmr_gb;
  logic [5:0]  tmr_timing;
  logic [6:0]  avg_cyc;
  logic [7:0]  listen;
  int          mismatches = 0, tests_run = 0, start_cycles = 0, cycles = 0;
  pdc_row_t    rows [2] = '{'{16'hA5C3, 7'h20}, '{16'h5A3C, 7'h04}};

  //==========================================================================
  // Clock, start pulse counter and timeout.
  always #5 clk_sys = ~clk_sys;
  // Counting high cycles catches both extra pulses and pulses wider than one cycle.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (start === 1'b1) start_cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  pdc_regs pdc_regs_inst (
    .clk_sys_i(clk_sys), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .filt_thr_set1_o(thr1), .filt_thr_set0_o(thr0), .filt_coef_en_o(coef_en),
    .filt_coef_long_o(coef_long), .filt_cfg2_o(cfg2), .gain_loop_in_sel_o(loop_sel),
    .gain_start_idx_o(gain_start), .gain_idx_max_o(gain_max), .gain_idx_min_o(gain_min),
    .gain_retrain_dis_o(retrain_dis), .fbe_ctrl_o(fbe), .gain_bw_o(gain_bw), .bad_err_thr_o(bad_thr),
    .timing_loop_error_level_thr_o(tl_thr), .linkup_error_level_thr_o(lu_thr),
    .trn_tmr_shift_o(tmr_shift), .trn_tmr_timing_o(tmr_timing), .trn_tmr_gain_a_o(tmr_ga),
    .trn_tmr_gain_b_o(tmr_gb), .active_link_cable_diag_start_o(start),
    .active_link_cable_diag_busy_o(busy), .active_link_cable_diag_done_i(done),
    .active_link_cable_diag_sum_i(sum), .tdr_cross_dis_o(cross_dis), .transmit_pair_bypass_o(tx_byp),
    .receive_pair_bypass_o(rx_byp), .tdr_avg_cycles_o(avg_cyc), .tdr_pulse_ctrl_o(pulse),
    .tdr_listen_len_o(listen));

  //==========================================================================
  // Tasks
  // One APB transfer; a leading edge keeps two transfers from assigning psel in one time step.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] wd, input logic [3:0] st);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {16'h0000, wd};
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    // The wait has no limit of its own; the bench timeout ends a hung transfer.
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rd(input logic [9:0] idx, input logic [15:0] exp);
    apb(1'b0, {idx, 2'b00}, 16'h0000, 4'h0);
    cmp("read", {exp, 1'b0}, {rd, err});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  //==========================================================================
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset words of every register.
    for (int s = 0; s < 16; s++) chk_rd(pdc_pkg::REG_IDX[s], pdc_pkg::REG_RST[s]);
    cmp("avg_reset", 64'd64, avg_cyc);
    // Each row writes one pattern to every register except the diagnostic control, then checks read-back and every field output.
    foreach (rows[r])
    begin
      for (int s = 0; s < 16; s++)
        if (s != 12) apb(1'b1, {pdc_pkg::REG_IDX[s], 2'b00}, rows[r].pat, 4'hF);
      for (int s = 0; s < 16; s++)
        if (s != 12) chk_rd(pdc_pkg::REG_IDX[s], rows[r].pat & pdc_pkg::REG_WMASK[s]);
      cmp("filter", {rows[r].pat[15:12], rows[r].pat[3:0], rows[r].pat[10], rows[r].pat[7:6]},
          {thr1, thr0, coef_en, coef_long});
      cmp("gain", {rows[r].pat[8], rows[r].pat[3:0], rows[r].pat[7:0], rows[r].pat[11]},
          {loop_sel, gain_start, gain_max, gain_min, retrain_dis});
      cmp("bad_thr", rows[r].pat[14:0], bad_thr);
      cmp("timing_thr", rows[r].pat[14:0], tl_thr);
      cmp("linkup_thr", rows[r].pat[14:0], lu_thr);
      cmp("timers", rows[r].pat[14:0], {tmr_shift, tmr_timing, tmr_ga, tmr_gb});
      cmp("whole", {rows[r].pat, rows[r].pat, rows[r].pat}, {cfg2, fbe, gain_bw});
      cmp("tdr", {rows[r].pat[14:12], rows[r].pat[3:0], rows[r].pat[15:8], rows[r].avg},
          {cross_dis, tx_byp, rx_byp, pulse, listen, avg_cyc});
    end
    // Reserved averaging code is kept as written and still gives the longest average.
    apb(1'b1, {pdc_pkg::IDX_CD_CTL1, 2'b00}, 16'h0700, 4'hF);
    chk_rd(pdc_pkg::IDX_CD_CTL1, 16'h0700);
    cmp("avg_rsvd", 64'd64, avg_cyc);
    // Upper byte strobe only, then a misaligned write that must leave the word alone.
    apb(1'b1, {pdc_pkg::IDX_FILT_CFG2, 2'b00}, 16'hFFFF, 4'h2);
    apb(1'b1, {pdc_pkg::IDX_FILT_CFG2, 2'b10}, 16'h1234, 4'hF);
    cmp("misaligned_err", 64'd1, err);
    chk_rd(pdc_pkg::IDX_FILT_CFG2, 16'hFF3C);
    apb(1'b0, 12'h400, 16'h0000, 4'h0);
    cmp("unmapped", 64'h1, {rd, err});
    // Diagnostic launch, refused relaunch while running, then completion.
    sum <= 8'hA5;
    apb(1'b1, {pdc_pkg::IDX_ACTIVE_LINK_CABLE_DIAG_CTL, 2'b00}, 16'h8001, 4'hF);
    @(posedge clk_sys);
    cmp("busy", 64'd1, busy);
    chk_rd(pdc_pkg::IDX_ACTIVE_LINK_CABLE_DIAG_CTL, 16'h1A51);
    apb(1'b1, {pdc_pkg::IDX_ACTIVE_LINK_CABLE_DIAG_CTL, 2'b00}, 16'h8001, 4'hF);
    done <= 1'b1;
    @(posedge clk_sys);
    done <= 1'b0;
    chk_rd(pdc_pkg::IDX_ACTIVE_LINK_CABLE_DIAG_CTL, 16'h0A51);
    apb(1'b1, {pdc_pkg::IDX_ACTIVE_LINK_CABLE_DIAG_CTL, 2'b00}, 16'h0001, 4'hF);
    repeat (2) @(posedge clk_sys);
    cmp("start_count", 64'd1, start_cycles);
    apb(1'b1, {pdc_pkg::IDX_ACTIVE_LINK_CABLE_DIAG_CTL, 2'b00}, 16'h8001, 4'hF);
    repeat (2) @(posedge clk_sys);
    cmp("relaunch", {32'd2, 1'b1}, {start_cycles, busy});
    // Reset in mid-run drops the open diagnostic and restores the reflectometry fields.
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    cmp("reset_out", {1'b0, pdc_pkg::RST_CD_CTL3[15:8], pdc_pkg::RST_AVG_CYC}, {busy, listen, avg_cyc});
    chk_rd(pdc_pkg::IDX_CD_CTL1, pdc_pkg::RST_CD_CTL1);
    tally_and_finish();
  end
endmodule // test_phy_dsp_and_cable_diag_regs
